/* File: obdft_core.sv */
// Behaviour
// - First detection stores pending code and snapshot
// - Second consecutive detection confirms, lamp on
// - Pattern B needs every monitor evaluated
// - Any malfunction clears the B counter
// - Clean pattern-B trip increments B counter
// - Lamp off when B counter reaches three
// - Non-misfire detection clears the A counter
// - Clean pattern-A trip increments A counter
// - Non-misfire code hidden at A forty
// - Hidden confirmed code and snapshot stay stored
// - Misfire detection clears the C counter
// - Clean pattern-C trip increments C counter
// - Misfire code hidden at C eighty
// - Pattern C: speed within 375 rpm
// - Pattern C: load within ten percent
// - Pattern C: coolant same side of 70
// - Misfire pending cleared after one C count
// - Misfire pending and snapshot cleared on OK
// - Second detection discards pending snapshot
// - Non-misfire pending cleared after pattern-B trip
// - Pending hidden when second trip passes
// - Drive count per stored code is readable
`timescale 1ns/10ps
`default_nettype none
module obdft_core #(
  parameter int N_FAULT = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire obdft_pkg::obdft_trip_s trip,
  input wire logic [N_FAULT-1:0] mal_det,
  input wire logic [N_FAULT-1:0] ok_det,
  input wire logic [N_FAULT-1:0] eval_done,
  input wire obdft_pkg::obdft_snap_s live,
  output logic fault_warning_lamp,
  output logic [N_FAULT-1:0] pending_fault_code,
  output logic [N_FAULT-1:0] confirmed_fault_code
);
  import obdft_pkg::*;

  localparam int SW = (N_FAULT > 1) ? $clog2(N_FAULT) : 1;

  // ===========================================================
  // Register bus state.
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [31:0] hrdata_reg;
  logic [N_FAULT-1:0] class_reg;
  logic [SW-1:0] sel_reg;
  logic erase, rd_take, wr_take;
  logic [31:0] rd_next;

  // ===========================================================
  // Trip-wide state.
  logic [N_FAULT-1:0] eval_seen_reg;
  logic [N_FAULT-1:0] det_now_vec;
  logic [N_FAULT-1:0] confirm_vec;
  logic [N_FAULT-1:0] conf_vec;
  logic [N_FAULT-1:0] hidden_vec;
  logic [N_FAULT-1:0] pend_show_vec;
  logic b_trip, b_inc, b_clr, b_at_limit;
  logic [1:0] b_cnt;
  logic lamp_reg;
  logic [6:0] drives_arr [N_FAULT];
  obdft_snap_s conf_snap_arr [N_FAULT];
  obdft_snap_s pend_snap_arr [N_FAULT];

  // ===========================================================
  // AHB-Lite slave: zero wait states, always OKAY.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign rd_take = hsel && htrans[1] && hready && !hwrite;
  assign wr_take = hsel && htrans[1] && hready && hwrite;

  // Address phase of a write is held for its data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else if (hready) begin
      wr_pend_reg <= wr_take;
      wr_addr_reg <= haddr[7:0];
    end
  end

  // Erase is a one-cycle pulse from a write of the control word.
  assign erase = wr_pend_reg && (wr_addr_reg == OBDFT_ADDR_CTRL) &&
                 hwdata[OBDFT_CTRL_ERASE_BIT];

  // Software-written class mask and detail selector.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      class_reg <= N_FAULT'(OBDFT_CLASS_RST);
      sel_reg <= SW'(OBDFT_SEL_RST);
    end else if (wr_pend_reg) begin
      if (wr_addr_reg == OBDFT_ADDR_CLASS) begin
        class_reg <= hwdata[N_FAULT-1:0];
      end
      if (wr_addr_reg == OBDFT_ADDR_SEL) begin
        sel_reg <= hwdata[SW-1:0];
      end
    end
  end

  // Read multiplexer; unmapped offsets read as zero.
  always_comb begin
    rd_next = 32'h0000_0000;
    unique case (haddr[7:0])
      OBDFT_ADDR_CLASS: rd_next[N_FAULT-1:0] = class_reg;
      OBDFT_ADDR_STATUS: begin
        rd_next[OBDFT_STAT_LAMP_BIT] = lamp_reg;
        rd_next[OBDFT_STAT_BCNT_LSB +: 2] = b_cnt;
      end
      OBDFT_ADDR_PEND: rd_next[N_FAULT-1:0] = pend_show_vec;
      OBDFT_ADDR_CONF: rd_next[N_FAULT-1:0] = conf_vec & ~hidden_vec;
      OBDFT_ADDR_STORED: rd_next[N_FAULT-1:0] = conf_vec;
      OBDFT_ADDR_SEL: rd_next[SW-1:0] = sel_reg;
      OBDFT_ADDR_DRIVES: rd_next[6:0] = drives_arr[sel_reg];
      OBDFT_ADDR_CSNAP: rd_next = conf_snap_arr[sel_reg];
      OBDFT_ADDR_PSNAP: rd_next = pend_snap_arr[sel_reg];
      default: rd_next = 32'h0000_0000;
    endcase
  end

  // Read data is registered at the address phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (rd_take) begin
      hrdata_reg <= rd_next;
    end
  end

  // ===========================================================
  // Pattern B: all monitors evaluated and no malfunction in trip.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      eval_seen_reg <= '0;
    end else if (erase || trip.trip_end) begin
      eval_seen_reg <= '0;
    end else begin
      eval_seen_reg <= eval_seen_reg | eval_done;
    end
  end

  assign b_trip = (&(eval_seen_reg | eval_done)) &&
                  !(|det_now_vec);
  assign b_inc = trip.trip_end && b_trip;
  assign b_clr = erase || (|mal_det);

  obdft_sat_cnt #(
    .W(2),
    .LIMIT(OBDFT_LIM_B)
  ) u_b_cnt (
    .hclk(hclk),
    .hresetn(hresetn),
    .clr(b_clr),
    .inc(b_inc),
    .count(b_cnt),
    .at_limit(b_at_limit)
  );

  // Lamp: a new confirmation wins over the pattern-B turn-off.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lamp_reg <= 1'b0;
    end else if (erase) begin
      lamp_reg <= 1'b0;
    end else if (trip.trip_end && (|confirm_vec)) begin
      lamp_reg <= 1'b1;
    end else if (b_at_limit) begin
      lamp_reg <= 1'b0;
    end
  end

  assign fault_warning_lamp = lamp_reg;
  assign pending_fault_code = pend_show_vec;
  assign confirmed_fault_code = conf_vec & ~hidden_vec;

  // ===========================================================
  // Per-fault memory, one independent copy per fault.
  for (genvar i = 0; i < N_FAULT; i++) begin : g_fault
    logic cls;
    logic mal_trip_reg;
    logic prev_det_reg, pend_reg, hide_reg;
    logic conf_reg;
    logic psnap_vld_reg;
    logic c_met_reg;
    logic c_match, c_now, det_now;
    logic a_inc, a_clr, a_lim;
    logic c_inc, c_clr, c_lim;
    logic [5:0] a_cnt;
    logic [6:0] c_cnt;
    obdft_snap_s trip_snap_reg;
    obdft_snap_s pend_snap_reg;
    obdft_snap_s conf_snap_reg;
    obdft_snap_s ref_snap, cap_snap;

    assign cls = class_reg[i];
    assign det_now = mal_trip_reg || mal_det[i];
    assign cap_snap = mal_trip_reg ? trip_snap_reg : live;
    assign ref_snap = conf_reg ? conf_snap_reg : pend_snap_reg;

    // Detection seen in the current trip and its snapshot.
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        mal_trip_reg <= 1'b0;
        trip_snap_reg <= '0;
      end else if (erase || trip.trip_end) begin
        mal_trip_reg <= 1'b0;
      end else if (mal_det[i] && !mal_trip_reg) begin
        mal_trip_reg <= 1'b1;
        trip_snap_reg <= live;
      end
    end

    // Live point compared against the stored snapshot.
    obdft_pat_c_cmp u_cmp (
      .live(live),
      .snap(ref_snap),
      .match(c_match)
    );

    // Pattern C is met once in the trip while a snapshot exists.
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        c_met_reg <= 1'b0;
      end else if (erase || trip.trip_end) begin
        c_met_reg <= 1'b0;
      end else if (c_match && (conf_reg || psnap_vld_reg)) begin
        c_met_reg <= 1'b1;
      end
    end

    assign c_now = c_met_reg ||
                   (c_match && (conf_reg || psnap_vld_reg));

    // Drive counters run only while a confirmed code is stored.
    assign a_clr = erase || (mal_det[i] && !cls);
    assign a_inc = trip.trip_end && !det_now && !cls && conf_reg &&
                   trip.pattern_a_met;
    assign c_clr = erase || (mal_det[i] && cls);
    assign c_inc = trip.trip_end && !det_now && cls && conf_reg &&
                   c_now;

    obdft_sat_cnt #(
      .W(6),
      .LIMIT(OBDFT_LIM_A)
    ) u_a_cnt (
      .hclk(hclk),
      .hresetn(hresetn),
      .clr(a_clr),
      .inc(a_inc),
      .count(a_cnt),
      .at_limit(a_lim)
    );

    obdft_sat_cnt #(
      .W(7),
      .LIMIT(OBDFT_LIM_C)
    ) u_c_cnt (
      .hclk(hclk),
      .hresetn(hresetn),
      .clr(c_clr),
      .inc(c_inc),
      .count(c_cnt),
      .at_limit(c_lim)
    );

    // Remembers whether the previous trip saw this fault.
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        prev_det_reg <= 1'b0;
      end else if (erase) begin
        prev_det_reg <= 1'b0;
      end else if (trip.trip_end) begin
        prev_det_reg <= det_now;
      end
    end

    // Pending code; a detection at trip end wins over every clear except erase.
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        pend_reg <= 1'b0;
      end else if (erase) begin
        pend_reg <= 1'b0;
      end else if (trip.trip_end && det_now) begin
        pend_reg <= 1'b1;
      end else if (cls && ok_det[i]) begin
        pend_reg <= 1'b0;
      end else if (trip.trip_end && !cls && b_trip) begin
        pend_reg <= 1'b0;
      end else if (c_inc) begin
        pend_reg <= 1'b0;
      end
    end

    // Pending snapshot kept from the first detecting trip only.
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        psnap_vld_reg <= 1'b0;
        pend_snap_reg <= '0;
      end else if (erase) begin
        psnap_vld_reg <= 1'b0;
        pend_snap_reg <= '0;
      end else if (trip.trip_end && det_now && prev_det_reg) begin
        psnap_vld_reg <= 1'b0;
        pend_snap_reg <= '0;
      end else if (trip.trip_end && det_now) begin
        psnap_vld_reg <= 1'b1;
        pend_snap_reg <= cap_snap;
      end else if ((cls && ok_det[i]) ||
                   (trip.trip_end && !cls && b_trip)) begin
        psnap_vld_reg <= 1'b0;
        pend_snap_reg <= '0;
      end
    end

    // A pass on the trip after a detection hides the pending code.
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        hide_reg <= 1'b0;
      end else if (erase || (trip.trip_end && det_now)) begin
        hide_reg <= 1'b0;
      end else if (ok_det[i] && pend_reg && !det_now) begin
        hide_reg <= 1'b1;
      end
    end

    // Confirmed code and snapshot; only erase removes them.
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        conf_reg <= 1'b0;
        conf_snap_reg <= '0;
      end else if (erase) begin
        conf_reg <= 1'b0;
        conf_snap_reg <= '0;
      end else if (confirm_vec[i]) begin
        conf_reg <= 1'b1;
        conf_snap_reg <= cap_snap;
      end
    end

    assign confirm_vec[i] = trip.trip_end && det_now && prev_det_reg;
    assign det_now_vec[i] = det_now;
    assign pend_show_vec[i] = pend_reg && !hide_reg;
    assign conf_vec[i] = conf_reg;
    assign hidden_vec[i] = cls ? c_lim : a_lim;
    assign drives_arr[i] = cls ? c_cnt : {1'b0, a_cnt};
    assign conf_snap_arr[i] = conf_snap_reg;
    assign pend_snap_arr[i] = pend_snap_reg;
  end

endmodule
`default_nettype wire

/* File: obdft_core_bench.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Self-checking bench for the fault memory block.
module obdft_core_bench;
  import obdft_pkg::*;
  localparam int NF = 8;
  localparam logic [NF-1:0] ALL = 8'hff;
  localparam obdft_snap_s SA = '{16'h0bb8, 8'h28, 8'sh5a};
  localparam obdft_snap_s SC = '{16'h0352, 8'h1e, 8'sh50};
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic hreadyout, hresp, lamp;
  logic [31:0] hrdata, rd;
  obdft_trip_s trip;
  obdft_snap_s live;
  logic [NF-1:0] mal_det, ok_det, eval_done, pend, conf;
  int n_mismatch = 0;
  int cmp_count = 0;
  obdft_snap_s ctab [6];
  int cexp [6];

  always #5 hclk = ~hclk;

  obdft_core #(.N_FAULT(NF)) i_dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .trip(trip),
    .mal_det(mal_det), .ok_det(ok_det), .eval_done(eval_done),
    .live(live), .fault_warning_lamp(lamp), .pending_fault_code(pend),
    .confirmed_fault_code(conf));
  obdft_monitor_model #(.N_FAULT(NF)) i_mon (.hclk(hclk), .trip(trip),
    .mal_det(mal_det), .ok_det(ok_det), .eval_done(eval_done),
    .live(live));

  // Counts one comparison and reports a difference.
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One single AHB-Lite word transfer; q is the read data.
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    hwrite <= 1'b0;
  endtask

  task automatic rchk(input string what, input logic [7:0] a,
                      input logic [31:0] exp);
    ahb(1'b0, a, 32'h0, rd);
    check(what, exp, rd);
  endtask

  // Runs one trip and lets its results settle.
  task automatic trip_go(input logic [NF-1:0] m, input logic [NF-1:0] o,
                         input logic [NF-1:0] e, input logic pa,
                         input obdft_snap_s lv);
    i_mon.run_trip(m, o, e, pa, lv);
    @(negedge hclk);
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Cuts a hang short well after the sequence should have ended.
  initial begin
    repeat (20000) @(posedge hclk);
    n_mismatch++;
    finish_test();
  end

  // Main sequence.
  initial begin
    ctab = '{'{16'h04ca, 8'h1e, 8'sh50}, '{16'h01da, 8'h1e, 8'sh50},
             '{16'h0352, 8'h22, 8'sh50}, '{16'h0352, 8'h1e, 8'sh45},
             '{16'h04c9, 8'h21, 8'sh46}, '{16'h01db, 8'h1b, 8'sh50}};
    cexp = '{0, 0, 0, 0, 1, 2};
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rchk("class", OBDFT_ADDR_CLASS, OBDFT_CLASS_RST);
    rchk("sel", OBDFT_ADDR_SEL, OBDFT_SEL_RST);
    rchk("unmapped", 8'h40, 32'h0);
    $display("register test done");
    ahb(1'b1, OBDFT_ADDR_SEL, 32'h2, rd);
    trip_go(8'h04, '0, ALL, 1'b1, SA);
    check("pending", 8'h04, pend);
    rchk("psnap", OBDFT_ADDR_PSNAP, SA);
    trip_go(8'h04, '0, ALL, 1'b1, SA);
    check("confirmed", 8'h04, conf);
    check("lamp", 1'b1, lamp);
    rchk("psnap", OBDFT_ADDR_PSNAP, 32'h0);
    trip_go('0, '0, 8'h7f, 1'b1, SA);
    rchk("status", OBDFT_ADDR_STATUS, 32'h1);
    check("pending", 8'h04, pend);
    repeat (2) trip_go('0, '0, ALL, 1'b1, SA);
    rchk("status", OBDFT_ADDR_STATUS, 32'h201);
    check("pending", 8'h00, pend);
    trip_go(8'h20, '0, ALL, 1'b1, SA);
    rchk("status", OBDFT_ADDR_STATUS, 32'h1);
    repeat (3) trip_go('0, '0, ALL, 1'b1, SA);
    rchk("status", OBDFT_ADDR_STATUS, 32'h300);
    check("lamp", 1'b0, lamp);
    check("pending", 8'h00, pend);
    rchk("drives", OBDFT_ADDR_DRIVES, 32'd7);
    repeat (33) trip_go('0, '0, ALL, 1'b1, SA);
    check("confirmed", 8'h00, conf);
    rchk("stored", OBDFT_ADDR_STORED, 32'h4);
    rchk("csnap", OBDFT_ADDR_CSNAP, SA);
    trip_go('0, '0, ALL, 1'b1, SA);
    rchk("drives", OBDFT_ADDR_DRIVES, 32'd40);
    $display("two-trip test done");
    ahb(1'b1, OBDFT_ADDR_SEL, 32'h0, rd);
    trip_go(8'h01, '0, ALL, 1'b1, SC);
    trip_go('0, 8'h01, ALL, 1'b1, SC);
    check("pending", 8'h00, pend);
    rchk("psnap", OBDFT_ADDR_PSNAP, 32'h0);
    repeat (2) trip_go(8'h01, '0, ALL, 1'b1, SC);
    check("confirmed", 8'h01, conf);
    for (int i = 0; i < 6; i++) begin
      trip_go('0, '0, ALL, 1'b1, ctab[i]);
      rchk("drives", OBDFT_ADDR_DRIVES, cexp[i]);
      check("pending", (cexp[i] == 0) ? 8'h01 : 8'h00, pend);
    end
    trip_go(8'h01, '0, ALL, 1'b1, SC);
    rchk("drives", OBDFT_ADDR_DRIVES, 32'd0);
    repeat (79) trip_go('0, '0, ALL, 1'b1, SC);
    check("confirmed", 8'h01, conf);
    trip_go('0, '0, ALL, 1'b1, SC);
    check("confirmed", 8'h00, conf);
    rchk("stored", OBDFT_ADDR_STORED, 32'h5);
    $display("misfire test done");
    ahb(1'b1, OBDFT_ADDR_SEL, 32'h2, rd);
    trip_go(8'h04, '0, ALL, 1'b1, SA);
    rchk("drives", OBDFT_ADDR_DRIVES, 32'd0);
    check("confirmed", 8'h04, conf);
    ahb(1'b1, OBDFT_ADDR_CTRL, 32'h1, rd);
    @(negedge hclk);
    check("pending", 8'h00, pend);
    rchk("stored", OBDFT_ADDR_STORED, 32'h0);
    $display("erase test done");
    trip_go(8'h08, '0, ALL, 1'b1, SA);
    check("pending", 8'h08, pend);
    trip_go('0, 8'h08, 8'h7f, 1'b1, SA);
    check("pending", 8'h00, pend);
    $display("pass-hide test done");
    finish_test();
  end
endmodule
`default_nettype wire

/* File: obdft_core_props.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Port checker for the fault memory and warning lamp block.
module obdft_core_props
  import obdft_pkg::*;
#(
  parameter int N_FAULT = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire obdft_pkg::obdft_trip_s trip,
  input wire logic [N_FAULT-1:0] mal_det,
  input wire logic fault_warning_lamp,
  input wire logic [N_FAULT-1:0] pending_fault_code,
  input wire logic [N_FAULT-1:0] confirmed_fault_code
);
  logic [N_FAULT-1:0] seen_reg;
  logic [N_FAULT-1:0] seen_all;
  logic rd_take;
  logic wr_take_reg;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Decodes taken reads and merges the detections of the running trip.
  assign rd_take = hsel && htrans[1] && hready && !hwrite;
  assign seen_all = seen_reg | mal_det;

  // Collects detections since the last trip end, flags write data phases.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seen_reg <= '0;
      wr_take_reg <= 1'b0;
    end else begin
      seen_reg <= trip.trip_end ? '0 : seen_all;
      wr_take_reg <= hsel && htrans[1] && hready && hwrite;
    end
  end

  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response was not OKAY");
  a_ready_high: assert property (hreadyout == 1'b1)
    else $error("slave inserted a wait state");
  a_pend_set: assert property (
    trip.trip_end |=>
    (pending_fault_code & $past(seen_all)) == $past(seen_all))
    else $error("detection in the trip left pending clear");
  a_pend_cause: assert property (
    trip.trip_end |=> (pending_fault_code & ~$past(pending_fault_code)
    & ~$past(seen_all)) == '0)
    else $error("pending code set without a detection");
  a_conf_cause: assert property (
    trip.trip_end |=> (confirmed_fault_code
    & ~$past(confirmed_fault_code) & ~$past(seen_all)) == '0)
    else $error("confirmed code set without a detection");
  a_lamp_conf: assert property (
    $rose(fault_warning_lamp) |->
    $past(trip.trip_end) && (confirmed_fault_code != '0))
    else $error("lamp lit without a confirmation at trip end");
  a_lamp_fall: assert property (
    $fell(fault_warning_lamp) |->
    $past(trip.trip_end, 2) || $past(wr_take_reg))
    else $error("lamp went off outside its turn-off points");
  a_conf_fall: assert property (
    ($past(confirmed_fault_code) & ~confirmed_fault_code) != '0 |->
    $past(trip.trip_end) || $past(wr_take_reg))
    else $error("confirmed code dropped in mid-trip");
  a_rdata_hold: assert property (
    hrdata != $past(hrdata) |-> $past(rd_take))
    else $error("read data changed without a read");
endmodule

bind obdft_core obdft_core_props #(.N_FAULT(N_FAULT)) u_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .trip(trip), .mal_det(mal_det),
  .fault_warning_lamp(fault_warning_lamp),
  .pending_fault_code(pending_fault_code),
  .confirmed_fault_code(confirmed_fault_code));
`default_nettype wire

/* File: obdft_monitor_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Diagnostic monitors and trip qualifier on the far side.
module obdft_monitor_model
  import obdft_pkg::*;
#(
  parameter int N_FAULT = 8
) (
  input wire logic hclk,
  output var obdft_pkg::obdft_trip_s trip,
  output logic [N_FAULT-1:0] mal_det,
  output logic [N_FAULT-1:0] ok_det,
  output logic [N_FAULT-1:0] eval_done,
  output var obdft_pkg::obdft_snap_s live
);
  // Operating point outside any trip, far from every stored snapshot.
  localparam obdft_snap_s PARK = '{16'hffff, 8'h00, 8'sh80};

  // Quiet monitors at time zero.
  initial begin
    trip = '0;
    mal_det = '0;
    ok_det = '0;
    eval_done = '0;
    live = PARK;
  end

  // One trip: detections, then OK results, then the trip end pulse.
  task automatic run_trip(input logic [N_FAULT-1:0] m,
                          input logic [N_FAULT-1:0] o,
                          input logic [N_FAULT-1:0] e, input logic pa,
                          input obdft_snap_s lv);
    @(posedge hclk);
    live <= lv;
    eval_done <= e;
    mal_det <= m;
    @(posedge hclk);
    mal_det <= '0;
    ok_det <= o;
    @(posedge hclk);
    ok_det <= '0;
    trip <= '{trip_end: 1'b1, pattern_a_met: pa};
    @(posedge hclk);
    trip <= '0;
    eval_done <= '0;
    live <= PARK;
  endtask
endmodule
`default_nettype wire

/* File: obdft_pat_c_cmp.sv */
`timescale 1ns/10ps
`default_nettype none
module obdft_pat_c_cmp
  import obdft_pkg::*;
(
  input wire obdft_pkg::obdft_snap_s live,
  input wire obdft_pkg::obdft_snap_s snap,
  output logic match
);

  // ===========================================================
  // Compares the live operating point with a stored snapshot.
  logic [15:0] rpm_diff;
  logic [7:0] load_diff;
  logic [11:0] load_err;
  logic cool_ok;

  // Absolute differences, scaled load error against the snapshot.
  always_comb begin
    rpm_diff = (live.rpm >= snap.rpm) ? live.rpm - snap.rpm
                                      : snap.rpm - live.rpm;
    load_diff = (live.load >= snap.load) ? live.load - snap.load
                                         : snap.load - live.load;
    load_err = {4'h0, load_diff} * OBDFT_LOAD_DIV;
    cool_ok = ((live.cool < OBDFT_COOL_THR) ==
               (snap.cool < OBDFT_COOL_THR));
  end

  // All three conditions must hold at the same time.
  assign match = (rpm_diff <= OBDFT_RPM_WIN) &&
                 (load_err <= {4'h0, snap.load}) &&
                 cool_ok;

endmodule
`default_nettype wire

/* File: obdft_pkg.sv */
package obdft_pkg;

  // ===========================================================
  // Register map, byte offsets on the AHB-Lite slave.
  localparam logic [7:0] OBDFT_ADDR_CTRL = 8'h00;
  localparam logic [7:0] OBDFT_ADDR_CLASS = 8'h04;
  localparam logic [7:0] OBDFT_ADDR_STATUS = 8'h08;
  localparam logic [7:0] OBDFT_ADDR_PEND = 8'h0c;
  localparam logic [7:0] OBDFT_ADDR_CONF = 8'h10;
  localparam logic [7:0] OBDFT_ADDR_STORED = 8'h14;
  localparam logic [7:0] OBDFT_ADDR_SEL = 8'h18;
  localparam logic [7:0] OBDFT_ADDR_DRIVES = 8'h1c;
  localparam logic [7:0] OBDFT_ADDR_CSNAP = 8'h20;
  localparam logic [7:0] OBDFT_ADDR_PSNAP = 8'h24;

  // ===========================================================
  // Field positions.
  localparam int OBDFT_CTRL_ERASE_BIT = 0;
  localparam int OBDFT_STAT_LAMP_BIT = 0;
  localparam int OBDFT_STAT_BCNT_LSB = 8;

  // ===========================================================
  // Reset values.
  localparam logic [31:0] OBDFT_CLASS_RST = 32'h0000_0003;
  localparam logic [31:0] OBDFT_SEL_RST = 32'h0000_0000;

  // ===========================================================
  // Counter limits and pattern-C tolerances.
  localparam int OBDFT_LIM_B = 3;
  localparam int OBDFT_LIM_A = 40;
  localparam int OBDFT_LIM_C = 80;
  localparam logic [15:0] OBDFT_RPM_WIN = 16'h0177;
  localparam logic [11:0] OBDFT_LOAD_DIV = 12'h00a;
  localparam logic signed [7:0] OBDFT_COOL_THR = 8'sh46;

  // ===========================================================
  // Freeze-frame snapshot, also the live operating point.
  typedef struct packed {
    logic [15:0] rpm;
    logic [7:0] load;
    logic signed [7:0] cool;
  } obdft_snap_s;

  // Monitor report of one trip for all faults.
  typedef struct packed {
    logic trip_end;
    logic pattern_a_met;
  } obdft_trip_s;

endpackage

/* File: obdft_sat_cnt.sv */
`timescale 1ns/10ps
`default_nettype none
module obdft_sat_cnt #(
  parameter int W = 7,
  parameter int LIMIT = 80
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clr,
  input wire logic inc,
  output logic [W-1:0] count,
  output logic at_limit
);

  // ===========================================================
  // Saturating counter; clear beats increment.
  localparam logic [W-1:0] LIM = W'(LIMIT);

  // Counts up by one per request and stops at the limit.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= '0;
    end else if (clr) begin
      count <= '0;
    end else if (inc && (count != LIM)) begin
      count <= count + 1'b1;
    end
  end

  assign at_limit = (count == LIM);

endmodule
`default_nettype wire
